// ===== core/tgc_pkg.sv
/*
  Constants, field layouts and carrier types for the trigger gate and counter clear block.
  Assumes one 20 MHz sample clock and an APB master with 32-bit data.
*/
// What this block does
// - Host clears any mix of three counters
// - Event tally is 32 bits, wraps
// - Off or software mode: clear at once
// - Edge or level mode, sync off: clear at edge
// - Sources: none, level, edge, software
// - Termination option, ignored for software
// - Input triggering only while sync off
// - Acquisition target: pre-trigger values excluded
// - Output target: acquisition continuous, included
// - Polarity picks edge direction and level
// - Each pulse while idle releases programmed count
// - Count 16383 means endless output
// - Count 0 ends and blocks release; triggers still counted
// - Software pulse refused unless software source
// - Gated output or all, bit 15 flag
package tgc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONFIG   = 8'h00;
  localparam logic [7:0] ADDR_COUNT    = 8'h04;
  localparam logic [7:0] ADDR_COMMAND  = 8'h08;
  localparam logic [7:0] ADDR_STATE    = 8'h0c;
  localparam logic [7:0] ADDR_EVENTS   = 8'h10;
  localparam logic [7:0] ADDR_TIMESTMP = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
  localparam logic [7:0] ADDR_IRQ_EN   = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_CLR  = 8'h20;
  localparam logic [7:0] ADDR_MEASURED = 8'h24;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CMD_PULSE_BIT   = 0;
  localparam int CMD_CLR_TS_BIT  = 1;
  localparam int CMD_CLR_MV_BIT  = 2;
  localparam int CMD_CLR_EV_BIT  = 3;
  localparam int STATUS_FLAG_BIT = 15;
  localparam int IRQ_BITS        = 3;
  localparam int IRQ_REFUSED     = 0;
  localparam int IRQ_EVENT       = 1;
  localparam int IRQ_CLEARED     = 2;

  // ----------------------------------------------------------------
  // Counts
  // ----------------------------------------------------------------
  localparam int          COUNT_W        = 14;
  localparam logic [13:0] COUNT_STOP     = 14'h0000;
  localparam logic [13:0] COUNT_ENDLESS  = 14'h3fff;
  localparam logic [13:0] COUNT_RESET    = 14'h0001;
  localparam logic [13:0] COUNT_LAST     = 14'h0001;
  localparam logic [31:0] TALLY_ONE      = 32'h0000_0001;
  localparam logic [31:0] TALLY_ZERO     = 32'h0000_0000;
  localparam logic [31:0] TALLY_MAX      = 32'hffff_ffff;

  typedef enum logic [1:0] {
    TGC_SRC_NONE,
    TGC_SRC_LEVEL,
    TGC_SRC_EDGE,
    TGC_SRC_SOFT
  } tgc_source_e;

  typedef enum {
    TGC_IDLE,
    TGC_RELEASE,
    TGC_ENDLESS
  } tgc_state_e;

  typedef struct packed {
    logic        sync_active;
    logic        untriggered_output_policy;
    logic        gate_target_select;
    logic        gate_polarity;
    logic        line_termination_on;
    tgc_source_e source;
  } tgc_config_s;

  typedef struct packed {
    logic timestamp;
    logic measured;
    logic events;
  } tgc_clear_s;

  localparam tgc_config_s CONFIG_RESET = tgc_config_s'('0);

endpackage : tgc_pkg

// ===== core/tgc_core.sv
/*
  Trigger gate and counter clear block with APB register access.
  Assumes a measurement cycle strobe on the sample clock and an asynchronous trigger pin.
*/
`timescale 1ns/10ps
module tgc_core
  import tgc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        trigger_pin,
  input  wire logic        meas_strobe,
  input  wire logic [14:0] meas_status,
  output logic             line_termination_on,
  output logic             acquire_enable,
  output logic             value_valid,
  output logic      [15:0] value_status,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  tgc_config_s         cfg;
  logic [COUNT_W-1:0]  values_per_event;
  logic [COUNT_W-1:0]  remaining;
  tgc_state_e          state;
  logic [31:0]         event_tally;
  logic [31:0]         measured_value_tally;
  logic [31:0]         timestamp;
  tgc_clear_s          pending;
  logic                clear_armed;
  logic [IRQ_BITS-1:0] irq_stat;
  logic [IRQ_BITS-1:0] irq_en;
  logic                sync_a;
  logic                sync_b;
  logic                trig_prev;

  logic        apb_access;
  logic        apb_wr;
  logic        host_pulse_request;
  logic        pulse_refused;
  logic        level_now;
  logic        edge_now;
  logic        input_mode;
  logic        fire;
  logic        gate_open;
  logic        clear_now;
  tgc_clear_s  clear_req;
  tgc_clear_s  apply;
  logic [IRQ_BITS-1:0] irq_set;

  function automatic logic is_input_source(input tgc_source_e s);
    return (s == TGC_SRC_LEVEL) || (s == TGC_SRC_EDGE);
  endfunction : is_input_source

  // ----------------------------------------------------------------
  // Trigger input
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync_a    <= 1'b0;
      sync_b    <= 1'b0;
      trig_prev <= 1'b0;
    end else if (clk_en) begin
      sync_a    <= trigger_pin;
      sync_b    <= sync_a;
      trig_prev <= sync_b;
    end
  end

  // Polarity folds both directions into one active-high view
  assign level_now  = cfg.gate_polarity ? sync_b : ~sync_b;
  assign edge_now   = cfg.gate_polarity ? (sync_b & ~trig_prev) : (~sync_b & trig_prev);
  // Shared pin: triggering from it is blocked while sync is in use
  assign input_mode = is_input_source(cfg.source) && !cfg.sync_active;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign apb_access = psel && penable && clk_en;
  assign apb_wr     = apb_access && pwrite;
  assign host_pulse_request = apb_wr && (paddr == ADDR_COMMAND) && pwdata[CMD_PULSE_BIT];
  assign pulse_refused = host_pulse_request && (cfg.source != TGC_SRC_SOFT);
  assign clear_req.timestamp = apb_wr && (paddr == ADDR_COMMAND) && pwdata[CMD_CLR_TS_BIT];
  assign clear_req.measured  = apb_wr && (paddr == ADDR_COMMAND) && pwdata[CMD_CLR_MV_BIT];
  assign clear_req.events    = apb_wr && (paddr == ADDR_COMMAND) && pwdata[CMD_CLR_EV_BIT];

  // Edge source: start only on an edge; level source never starts; software: accepted pulse
  assign fire = (cfg.source == TGC_SRC_EDGE && input_mode && edge_now) ||
                (cfg.source == TGC_SRC_SOFT && host_pulse_request);

  // ----------------------------------------------------------------
  // Configuration
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg              <= CONFIG_RESET;
      values_per_event <= COUNT_RESET;
      irq_en           <= '0;
    end else if (apb_wr) begin
      if (paddr == ADDR_CONFIG) begin
        cfg <= tgc_config_s'(pwdata[$bits(tgc_config_s)-1:0]);
      end
      if (paddr == ADDR_COUNT) begin
        values_per_event <= pwdata[COUNT_W-1:0];
      end
      if (paddr == ADDR_IRQ_EN) begin
        irq_en <= pwdata[IRQ_BITS-1:0];
      end
    end
  end

  // Termination is meaningless for a host-driven source
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      line_termination_on <= 1'b0;
    end else if (clk_en) begin
      line_termination_on <= cfg.line_termination_on && (cfg.source != TGC_SRC_SOFT);
    end
  end

  // ----------------------------------------------------------------
  // Release state machine
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state     <= TGC_IDLE;
      remaining <= '0;
    end else if (clk_en) begin
      if (apb_wr && paddr == ADDR_COUNT && pwdata[COUNT_W-1:0] == COUNT_STOP) begin
        state     <= TGC_IDLE;
        remaining <= '0;
      end else begin
        unique case (state)
          TGC_IDLE: begin
            if (fire && values_per_event == COUNT_ENDLESS) begin
              state <= TGC_ENDLESS;
            end else if (fire && values_per_event != COUNT_STOP) begin
              state     <= TGC_RELEASE;
              remaining <= values_per_event;
            end
          end
          TGC_RELEASE: begin
            if (meas_strobe) begin
              remaining <= remaining - COUNT_LAST;
              if (remaining == COUNT_LAST) begin
                state <= TGC_IDLE;
              end
            end
          end
          TGC_ENDLESS: begin
            state <= TGC_ENDLESS;
          end
        endcase
      end
    end
  end

  assign gate_open = (state != TGC_IDLE) ||
                     (cfg.source == TGC_SRC_LEVEL && input_mode && level_now) ||
                     (cfg.source == TGC_SRC_NONE);

  // ----------------------------------------------------------------
  // Output of values
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      value_valid    <= 1'b0;
      value_status   <= '0;
      acquire_enable <= 1'b0;
    end else if (clk_en) begin
      // Acquisition target gates the front end; output target keeps it running
      acquire_enable <= cfg.gate_target_select ? 1'b1 : gate_open;
      value_valid    <= meas_strobe && (gate_open || cfg.untriggered_output_policy);
      if (meas_strobe) begin
        value_status <= {gate_open, meas_status};
      end
    end
  end

  // ----------------------------------------------------------------
  // Counters and clears
  // ----------------------------------------------------------------
  assign clear_now = input_mode ? edge_now : 1'b1;
  assign apply.timestamp = (pending.timestamp || clear_req.timestamp) && clear_now;
  assign apply.measured  = (pending.measured  || clear_req.measured)  && clear_now;
  assign apply.events    = (pending.events    || clear_req.events)    && clear_now;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pending     <= '0;
      clear_armed <= 1'b0;
    end else if (clk_en) begin
      pending.timestamp <= (pending.timestamp || clear_req.timestamp) && !clear_now;
      pending.measured  <= (pending.measured  || clear_req.measured)  && !clear_now;
      pending.events    <= (pending.events    || clear_req.events)    && !clear_now;
      clear_armed       <= |{apply.timestamp, apply.measured, apply.events};
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      event_tally          <= TALLY_ZERO;
      measured_value_tally <= TALLY_ZERO;
      timestamp            <= TALLY_ZERO;
    end else if (clk_en) begin
      // A clear on the counting edge wins, so the edge itself starts from zero
      event_tally          <= apply.events ? TALLY_ZERO :
                              (fire ? event_tally + TALLY_ONE : event_tally);
      measured_value_tally <= apply.measured ? TALLY_ZERO :
                              (meas_strobe ? measured_value_tally + TALLY_ONE : measured_value_tally);
      timestamp            <= apply.timestamp ? TALLY_ZERO : timestamp + TALLY_ONE;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  assign irq_set = {clear_armed, fire, pulse_refused};

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat <= '0;
      irq      <= 1'b0;
    end else if (clk_en) begin
      // Set wins over a same-cycle clear
      if (apb_wr && paddr == ADDR_IRQ_CLR) begin
        irq_stat <= (irq_stat & ~pwdata[IRQ_BITS-1:0]) | irq_set;
      end else begin
        irq_stat <= irq_stat | irq_set;
      end
      irq <= |(irq_stat & irq_en);
    end
  end

  // ----------------------------------------------------------------
  // APB read side
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= '0;
      if (psel && !penable) begin
        unique case (paddr)
          ADDR_CONFIG:   prdata <= 32'(cfg);
          ADDR_COUNT:    prdata <= 32'(values_per_event);
          ADDR_COMMAND:  prdata <= '0;
          ADDR_STATE:    prdata <= 32'({pending, state != TGC_IDLE, remaining});
          ADDR_EVENTS:   prdata <= event_tally;
          ADDR_TIMESTMP: prdata <= timestamp;
          ADDR_IRQ_STAT: prdata <= 32'(irq_stat);
          ADDR_IRQ_EN:   prdata <= 32'(irq_en);
          ADDR_IRQ_CLR:  prdata <= '0;
          ADDR_MEASURED: prdata <= measured_value_tally;
          default: begin
            pslverr <= 1'b1;
          end
        endcase
        // Software pulse on a wrong source answers with an error
        if (pwrite && paddr == ADDR_COMMAND && pwdata[CMD_PULSE_BIT] &&
            cfg.source != TGC_SRC_SOFT) begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_TALLY_WRAP: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && fire && !apply.events && event_tally == TALLY_MAX |=> event_tally == TALLY_ZERO)
    else $error("event tally did not wrap");
  AST_CLEAR_NOW: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && clear_req.events && !input_mode |=> event_tally == TALLY_ZERO)
    else $error("immediate clear missed");
  AST_CLEAR_WAIT: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && clear_req.events && input_mode && !edge_now |=> pending.events)
    else $error("clear not held pending");
  AST_STOP: assert property (@(posedge clock) disable iff (!rst_n)
    apb_wr && paddr == ADDR_COUNT && pwdata[COUNT_W-1:0] == COUNT_STOP |=> state == TGC_IDLE)
    else $error("count zero did not stop");
  AST_REFUSE: assert property (@(posedge clock) disable iff (!rst_n)
    psel && !penable && clk_en && pwrite && paddr == ADDR_COMMAND && pwdata[CMD_PULSE_BIT] &&
    cfg.source != TGC_SRC_SOFT |=> pslverr && pready)
    else $error("wrong-source pulse not refused");
  AST_ENDLESS: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && state == TGC_ENDLESS && !apb_wr |=> state == TGC_ENDLESS)
    else $error("endless output ended");
  AST_TERM: assert property (@(posedge clock) disable iff (!rst_n)
    cfg.source == TGC_SRC_SOFT && $stable(cfg) |=> !line_termination_on)
    else $error("termination on for software source");
  AST_FLAG: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && meas_strobe |=> value_status[STATUS_FLAG_BIT] == $past(gate_open))
    else $error("status flag wrong");
  AST_RELEASE: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && state == TGC_RELEASE && meas_strobe && remaining == COUNT_LAST && !apb_wr |=> state == TGC_IDLE)
    else $error("release did not end");

  // ----------------------------------------------------------------
  // Multi-step checks
  // ----------------------------------------------------------------
  // Release may start: idle, finite count, no count write racing it
  sequence s_idle_counted;
    state == TGC_IDLE && values_per_event != COUNT_STOP &&
    values_per_event != COUNT_ENDLESS && !(apb_wr && paddr == ADDR_COUNT);
  endsequence
  sequence s_soft_pulse;
    clk_en && cfg.source == TGC_SRC_SOFT && host_pulse_request;
  endsequence
  sequence s_input_edge;
    clk_en && cfg.source == TGC_SRC_EDGE && input_mode && edge_now;
  endsequence
  // Two stages, so a sampled level reaches sync_b two clocks later
  sequence s_pin_held;
    clk_en && trigger_pin ##1 clk_en && trigger_pin;
  endsequence
  sequence s_clear_held;
    clk_en && clear_req.timestamp && input_mode && !edge_now;
  endsequence
  sequence s_pending_edge;
    clk_en && pending.measured && input_mode && edge_now;
  endsequence

  AST_SOFT_START: assert property (@(posedge clock) disable iff (!rst_n)
    s_soft_pulse and s_idle_counted |=> state == TGC_RELEASE && remaining == $past(values_per_event))
    else $error("software pulse did not start a release");
  AST_EDGE_START: assert property (@(posedge clock) disable iff (!rst_n)
    s_input_edge and s_idle_counted |=> state == TGC_RELEASE && remaining == $past(values_per_event))
    else $error("trigger edge did not start a release");
  AST_SYNC_DEPTH: assert property (@(posedge clock) disable iff (!rst_n)
    s_pin_held |=> sync_b)
    else $error("synchroniser did not pass the pin");
  AST_CLEAR_TS_WAIT: assert property (@(posedge clock) disable iff (!rst_n)
    s_clear_held |=> pending.timestamp)
    else $error("timestamp clear not held pending");
  AST_PENDING_APPLY: assert property (@(posedge clock) disable iff (!rst_n)
    s_pending_edge |=> measured_value_tally == TALLY_ZERO && !pending.measured)
    else $error("pending clear not applied at edge");
  AST_SYNC_BLOCK: assert property (@(posedge clock) disable iff (!rst_n)
    cfg.sync_active && cfg.source != TGC_SRC_SOFT |-> !fire)
    else $error("trigger taken while sync in use");
  AST_LEVEL_GATE: assert property (@(posedge clock) disable iff (!rst_n)
    cfg.source == TGC_SRC_LEVEL && input_mode && state == TGC_IDLE |-> gate_open == (sync_b == cfg.gate_polarity))
    else $error("level gate wrong");
  AST_ACQ_FREE: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && cfg.gate_target_select |=> acquire_enable)
    else $error("acquisition stopped for output target");
  AST_ACQ_GATED: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && !cfg.gate_target_select |=> acquire_enable == $past(gate_open))
    else $error("acquisition not gated");
  AST_GATED_OUT: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && meas_strobe && !gate_open && !cfg.untriggered_output_policy |=> !value_valid)
    else $error("untriggered value released");
  AST_ALL_OUT: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && meas_strobe && cfg.untriggered_output_policy |=> value_valid)
    else $error("value dropped in output-all policy");
  AST_REFUSE_FLAG: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && pulse_refused |=> irq_stat[IRQ_REFUSED])
    else $error("refused pulse not flagged");

endmodule : tgc_core

// ===== dv/tgc_far_side.sv
/*
  Far side model: measurement strobe, status word and trigger pin.
  Assumes the bench sets the wanted pin level on pin_req.
*/
`timescale 1ns/10ps
module tgc_far_side (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        pin_req,
  output logic             trigger_pin,
  output logic             meas_strobe,
  output logic      [14:0] meas_status
);
  logic [1:0] phase;

  // Strobe every fourth cycle, status walks a shift pattern
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase       <= 2'h0;
      meas_strobe <= 1'b0;
      meas_status <= 15'h0001;
    end else begin
      phase       <= phase + 2'h1;
      meas_strobe <= (phase == 2'h3);
      if (phase == 2'h3) begin
        meas_status <= {meas_status[13:0], meas_status[14] ^ meas_status[13]};
      end
    end
  end

  // Pin is registered on the block's clock; it moves just after an edge
  always_ff @(posedge clock) begin
    trigger_pin <= pin_req;
  end
endmodule : tgc_far_side

// ===== dv/tb.sv
/*
  Self-checking bench for the trigger gate block over APB.
  Assumes the far side model in tgc_far_side and a 20 MHz clock.
*/
`timescale 1ns/10ps
module tb;
  import tgc_pkg::*;
  logic        clock, rst_n, psel, penable, pwrite, pin_req, pready, pslverr, err;
  logic        trigger_pin, meas_strobe, line_termination_on, acquire_enable, value_valid, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, ev0;
  logic [14:0] meas_status, last_st;
  logic [15:0] value_status;
  int          failures, n_tests, n_valid, n_flag, base, fbase, cyc, n, pol;
  int          seed = 32'haafc7aa4;

  tgc_core dut (.clock(clock), .rst_n(rst_n), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trigger_pin(trigger_pin), .meas_strobe(meas_strobe),
    .meas_status(meas_status), .line_termination_on(line_termination_on),
    .acquire_enable(acquire_enable), .value_valid(value_valid), .value_status(value_status),
    .irq(irq));
  tgc_far_side far (.clock(clock), .rst_n(rst_n), .pin_req(pin_req), .trigger_pin(trigger_pin),
    .meas_strobe(meas_strobe), .meas_status(meas_status));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chk_rng(input string nm, input int lo, input int hi, input logic [31:0] g);
    n_tests++;
    if ($isunknown(g) || g < lo || g > hi) begin
      failures++;
      $display("CHECK FAILED %s expected %0d..%0d seen %h", nm, lo, hi, g);
    end
  endtask : chk_rng
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    // No local limit; the cycle ceiling ends a hang
    while (pready !== 1'b1) begin
      @(posedge clock);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic tick(input int k);
    repeat (k) @(posedge clock);
  endtask : tick
  function automatic logic [31:0] cfg(input logic [1:0] s, input logic [4:0] f);
    return {25'h0, f, s};
  endfunction : cfg
  task automatic report_and_stop();
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // Count released values; status tail must copy the strobe's word
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      report_and_stop();
    end
    if (meas_strobe === 1'b1) last_st <= meas_status;
    if (value_valid === 1'b1) begin
      n_valid++;
      if (value_status[15] === 1'b1) n_flag++;
      chk("status_low", {17'h0, last_st}, {17'h0, value_status[14:0]});
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, pin_req, paddr, pwdata} = '0;
    rst_n = 1'b0;
    tick(20);
    rst_n <= 1'b1;
    apb(0, ADDR_COUNT, 0);
    chk("count_reset", {18'h0, COUNT_RESET}, rd);
    apb(0, 8'h3c, 0);
    chk("unmapped_err", 1, {31'h0, err});
    base = n_valid;
    tick(40);
    chk_rng("none_open", 8, 11, n_valid - base);
    apb(1, ADDR_COMMAND, 32'h1);
    chk("pulse_refused", 1, {31'h0, err});
    apb(0, ADDR_IRQ_STAT, 0);
    chk("irq_status", 1, {31'h0, rd[IRQ_REFUSED]});
    chk("irq_masked", 0, {31'h0, irq});
    apb(1, ADDR_IRQ_EN, 32'h1);
    tick(2);
    chk("irq_on", 1, {31'h0, irq});
    apb(1, ADDR_IRQ_CLR, 32'h1);
    tick(2);
    chk("irq_off", 0, {31'h0, irq});
    // Software pulses: first the smallest count, then random ones
    apb(1, ADDR_CONFIG, cfg(TGC_SRC_SOFT, 5'h0));
    for (int i = 0; i < 3; i++) begin
      n = (i == 0) ? 1 : 1 + ($unsigned($random(seed)) % 8);
      apb(1, ADDR_COUNT, n);
      base = n_valid;
      apb(1, ADDR_COMMAND, 32'h1);
      chk("pulse_ok", 0, {31'h0, err});
      tick(80);
      chk("soft_release", n, n_valid - base);
    end
    apb(1, ADDR_COMMAND, 32'he);
    apb(0, ADDR_EVENTS, 0);
    chk("events_clr", TALLY_ZERO, rd);
    apb(0, ADDR_TIMESTMP, 0);
    chk_rng("ts_clr", 0, 20, rd);
    apb(0, ADDR_MEASURED, 0);
    chk_rng("mv_clr", 0, 20, rd);
    apb(1, ADDR_COMMAND, 32'h1);
    tick(80);
    apb(0, ADDR_EVENTS, 0);
    chk("event_count", 1, rd);
    apb(1, ADDR_COUNT, {18'h0, COUNT_ENDLESS});
    base = n_valid;
    apb(1, ADDR_COMMAND, 32'h1);
    tick(80);
    chk_rng("endless", 17, 21, n_valid - base);
    apb(1, ADDR_COUNT, {18'h0, COUNT_STOP});
    tick(8);
    base = n_valid;
    tick(40);
    chk("stopped", 0, n_valid - base);
    // Everything goes out, only gated values carry the flag
    apb(1, ADDR_CONFIG, cfg(TGC_SRC_SOFT, 5'h08));
    apb(1, ADDR_COUNT, 32'h2);
    tick(8);
    base = n_valid;
    fbase = n_flag;
    tick(40);
    chk_rng("all_out", 8, 11, n_valid - base);
    chk("no_flag", 0, n_flag - fbase);
    apb(1, ADDR_COMMAND, 32'h1);
    tick(60);
    chk("flagged", 2, n_flag - fbase);
    // Edge mode, both polarities, clear held until the edge
    n = 1 + ($unsigned($random(seed)) % 8);
    apb(1, ADDR_COUNT, n);
    for (pol = 0; pol < 2; pol++) begin
      pin_req <= !pol;
      apb(1, ADDR_CONFIG, cfg(TGC_SRC_EDGE, {3'h0, pol[0], pol[0]}));
      tick(2);
      chk("termination", pol, {31'h0, line_termination_on});
      apb(0, ADDR_EVENTS, 0);
      ev0 = rd;
      apb(1, ADDR_COMMAND, 32'he);
      tick(10);
      apb(0, ADDR_EVENTS, 0);
      chk("clr_held", ev0, rd);
      base = n_valid;
      pin_req <= pol;
      tick(80);
      chk("edge_release", n, n_valid - base);
      apb(0, ADDR_EVENTS, 0);
      chk_rng("clr_at_edge", 0, 1, rd);
    end
    pin_req <= 1'b0;
    apb(1, ADDR_CONFIG, cfg(TGC_SRC_EDGE, 5'h12));
    tick(10);
    base = n_valid;
    pin_req <= 1'b1;
    tick(60);
    chk("sync_blocks", 0, n_valid - base);
    // Level mode with acquisition target, then output target
    pin_req <= 1'b0;
    apb(1, ADDR_CONFIG, cfg(TGC_SRC_LEVEL, 5'h02));
    tick(20);
    chk("acq_closed", 0, {31'h0, acquire_enable});
    base = n_valid;
    pin_req <= 1'b1;
    tick(40);
    chk_rng("level_on", 8, 10, n_valid - base);
    chk("acq_open", 1, {31'h0, acquire_enable});
    pin_req <= 1'b0;
    tick(10);
    base = n_valid;
    tick(40);
    chk("level_off", 0, n_valid - base);
    apb(1, ADDR_CONFIG, cfg(TGC_SRC_LEVEL, 5'h06));
    tick(4);
    chk("acq_free", 1, {31'h0, acquire_enable});
    report_and_stop();
  end
endmodule : tb
